// [verilog/crc_pkg.sv]
package crc_pkg;
   ////////////////////////////////////////////////////////////////////////
   // bus widths
   localparam int CRC_DW = 32;
   localparam int CRC_AW = 32;
   localparam int CRC_DEC_W = 8;
   ////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] CRC_ADDR_CTRL = 8'h00;
   localparam logic [7:0] CRC_ADDR_MODE = 8'h04;
   localparam logic [7:0] CRC_ADDR_COUNT = 8'h08;
   localparam logic [7:0] CRC_ADDR_RELOAD = 8'h0c;
   localparam logic [7:0] CRC_ADDR_IE = 8'h10;
   ////////////////////////////////////////////////////////////////////////
   // control register bit positions
   localparam int CRC_BIT_OVF = 7;
   localparam int CRC_BIT_EXF = 6;
   localparam int CRC_BIT_RCLK = 5;
   localparam int CRC_BIT_TX_CLOCK_SELECT = 4;
   localparam int CRC_BIT_EXEN = 3;
   localparam int CRC_BIT_RUN = 2;
   localparam int CRC_BIT_TC = 1;
   localparam int CRC_BIT_CPRL = 0;
   // mode and enable register bit positions
   localparam int CRC_BIT_DOWN_COUNT_ENABLE = 0;
   localparam int CRC_BIT_IE = 0;
   ////////////////////////////////////////////////////////////////////////
   // reset values and counter limits
   localparam logic [7:0] CRC_CTRL_RST = 8'h00;
   localparam logic [15:0] CRC_CNT_RST = 16'h0000;
   localparam logic [15:0] CRC_CNT_MAX = 16'hffff;
   localparam logic [15:0] CRC_CNT_ONE = 16'h0001;
   localparam logic [31:0] CRC_DATA_ZERO = 32'h0000_0000;
   ////////////////////////////////////////////////////////////////////////
   // internal clock dividers (pclk taken as the oscillator)
   localparam logic [3:0] CRC_DIV_MACHINE = 4'hc;
   localparam logic [3:0] CRC_DIV_STATE = 4'h2;
   localparam logic [3:0] CRC_DIV_ONE = 4'h1;
   localparam logic [3:0] CRC_DIV_ZERO = 4'h0;
endpackage : crc_pkg

// [verilog/crc_edge_sync.sv]
`timescale 1ns/1ps
module crc_edge_sync
   import crc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // asynchronous pin
   input wire logic pin,
   // synchronised level and falling edge pulse
   output logic level,
   output logic fall
);
   typedef struct packed {
      logic s1;
      logic s2;
      logic prev;
      logic fall;
   } crc_sync_t;

   crc_sync_t st_ff;
   crc_sync_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // two-stage synchroniser, then falling edge detect on stage two
   always_comb begin
      nxt_st = st_ff;
      nxt_st.s1 = pin;
      nxt_st.s2 = st_ff.s1;
      nxt_st.prev = st_ff.s2;
      nxt_st.fall = st_ff.prev & ~st_ff.s2;
   end

   // state register, idle high like a pulled-up pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{s1: 1'b1, s2: 1'b1, prev: 1'b1, fall: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign level = st_ff.s2;
   assign fall = st_ff.fall;
endmodule : crc_edge_sync

// [verilog/crc_prescaler.sv]
`timescale 1ns/1ps
module crc_prescaler
   import crc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // one-cycle ticks
   output logic tick_machine,
   output logic tick_state
);
   typedef struct packed {
      logic [3:0] cnt;
      logic t_mach;
      logic t_state;
   } crc_presc_t;

   crc_presc_t st_ff;
   crc_presc_t nxt_st;

   ////////////////////////////////////////////////////////////////////////
   // free-running divide by twelve, state tick on every second cycle
   always_comb begin
      nxt_st = st_ff;
      if (st_ff.cnt == CRC_DIV_MACHINE - CRC_DIV_ONE) begin
         nxt_st.cnt = CRC_DIV_ZERO;
      end else begin
         nxt_st.cnt = st_ff.cnt + CRC_DIV_ONE;
      end
      nxt_st.t_mach = (st_ff.cnt == CRC_DIV_MACHINE - CRC_DIV_ONE);
      nxt_st.t_state = (st_ff.cnt[0] == CRC_DIV_STATE[0] ^ 1'b1);
   end

   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{cnt: CRC_DIV_ZERO, t_mach: 1'b0, t_state: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign tick_machine = st_ff.t_mach;
   assign tick_state = st_ff.t_state;
endmodule : crc_prescaler

// [verilog/crc_counter16.sv]
`timescale 1ns/1ps
// Contract
// - select bit low counts pclk/12 ticks; high counts falling edges of count pin
// - capture without trigger enable is plain 16-bit counter, overflow flag on wrap
// - capture with trigger enable copies count into reload on trigger falling edge
// - qualifying trigger edge sets external flag; it shares the overflow interrupt
// - capture mode never reloads the count and keeps counting through a capture
// - reset clears down-count enable, so counting starts upward only
// - up auto-reload wraps at all-ones, sets overflow, loads the reload pair
// - up auto-reload with trigger enable reloads on trigger edge and sets external flag
// - overflow requests interrupt only while software interrupt enable is set
// - down-count enabled, trigger pin high: count up, wrap reloads, overflow flag
// - down-count enabled, trigger pin low: count down, underflow at reload loads all-ones
// - with down-count enabled external flag toggles on every wrap, no interrupt
// - external flag cleared by software or by a down-count wrap toggle; ignored for interrupt with down-count
// - receive clock select picks this counter's overflow, else other timer's
// - transmit clock select picks this counter's overflow, else other timer's
// - in baud mode a rollover sets no overflow flag and no interrupt
// - in baud mode internal clocking steps every pclk/2 state time
// - in baud mode a trigger edge sets external flag but never reloads
module crc_counter16
   import crc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [CRC_AW-1:0] paddr,
   input wire logic [CRC_DW-1:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [CRC_DW-1:0] prdata,
   output logic pready,
   output logic pslverr,
   // external pins
   input wire logic ext_count_pin,
   input wire logic ext_trigger_pin,
   // serial port rate clocks
   input wire logic other_timer_ovf,
   output logic rx_baud_tick,
   output logic tx_baud_tick,
   // timer interrupt request
   output logic irq
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic down_count_enable;
      logic ie;
      logic [15:0] cnt;
      logic [15:0] rld;
      logic [CRC_DW-1:0] rdata;
      logic slverr;
      logic irq;
      logic rx_tick;
      logic tx_tick;
   } crc_state_t;

   crc_state_t st_ff;
   crc_state_t nxt_st;

   logic cnt_fall;
   logic trig_fall;
   logic trig_level;
   logic tick_mach;
   logic tick_state;

   ////////////////////////////////////////////////////////////////////////
   // pin synchronisers and internal clock divider
   crc_edge_sync u_count_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_count_pin),
      .level(),
      .fall(cnt_fall)
   );

   crc_edge_sync u_trig_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin(ext_trigger_pin),
      .level(trig_level),
      .fall(trig_fall)
   );

   crc_prescaler u_presc (
      .pclk(pclk),
      .presetn(presetn),
      .tick_machine(tick_mach),
      .tick_state(tick_state)
   );

   ////////////////////////////////////////////////////////////////////////
   // mode decode and counting events
   logic baud;
   logic capture;
   logic updown;
   logic step;
   logic trig;
   logic at_max;

   always_comb begin
      baud = st_ff.ctrl[CRC_BIT_RCLK] | st_ff.ctrl[CRC_BIT_TX_CLOCK_SELECT];
      capture = st_ff.ctrl[CRC_BIT_CPRL] & ~baud;
      updown = st_ff.down_count_enable & ~baud & ~capture;
      // internal rate depends on baud mode
      if (st_ff.ctrl[CRC_BIT_TC]) begin
         step = cnt_fall;
      end else if (baud) begin
         step = tick_state;
      end else begin
         step = tick_mach;
      end
      step = step & st_ff.ctrl[CRC_BIT_RUN];
      trig = st_ff.ctrl[CRC_BIT_EXEN] & trig_fall;
      at_max = (st_ff.cnt == CRC_CNT_MAX);
   end

   ////////////////////////////////////////////////////////////////////////
   // apb decode
   logic setup;
   logic wr;
   logic hit;
   logic [CRC_DEC_W-1:0] offs;
   logic wr_ctrl;
   logic wr_mode;
   logic wr_cnt;
   logic wr_rld;
   logic wr_ie;

   always_comb begin
      setup = psel & ~penable;
      wr = psel & penable & pwrite;
      offs = paddr[CRC_DEC_W-1:0];
      hit = (paddr[CRC_AW-1:CRC_DEC_W] == '0) &&
            (offs == CRC_ADDR_CTRL || offs == CRC_ADDR_MODE ||
             offs == CRC_ADDR_COUNT || offs == CRC_ADDR_RELOAD ||
             offs == CRC_ADDR_IE);
      wr_ctrl = wr & hit & (offs == CRC_ADDR_CTRL) & pstrb[0];
      wr_mode = wr & hit & (offs == CRC_ADDR_MODE) & pstrb[0];
      wr_cnt = wr & hit & (offs == CRC_ADDR_COUNT);
      wr_rld = wr & hit & (offs == CRC_ADDR_RELOAD);
      wr_ie = wr & hit & (offs == CRC_ADDR_IE) & pstrb[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // next state: counter, flags, registers, outputs
   logic wrap;
   logic ovf_set;
   logic exf_set;
   logic exf_tog;
   logic ovf_keep;
   logic exf_keep;
   logic [CRC_DW-1:0] rd;

   always_comb begin
      nxt_st = st_ff;
      wrap = 1'b0;
      ovf_set = 1'b0;
      exf_set = 1'b0;
      exf_tog = 1'b0;
      if (capture) begin
         // free count, capture taps the current value
         if (step) begin
            nxt_st.cnt = st_ff.cnt + CRC_CNT_ONE;
            wrap = at_max;
         end
         ovf_set = wrap;
         if (trig) begin
            nxt_st.rld = st_ff.cnt;
            exf_set = 1'b1;
         end
      end else if (updown) begin
         // direction follows the trigger pin level
         if (step && trig_level) begin
            if (at_max) begin
               nxt_st.cnt = st_ff.rld;
               wrap = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt + CRC_CNT_ONE;
            end
         end else if (step) begin
            if (st_ff.cnt == st_ff.rld) begin
               nxt_st.cnt = CRC_CNT_MAX;
               wrap = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt - CRC_CNT_ONE;
            end
         end
         ovf_set = wrap;
         exf_tog = wrap;
      end else begin
         // up-only auto-reload and baud generation
         if (step) begin
            if (at_max) begin
               nxt_st.cnt = st_ff.rld;
               wrap = 1'b1;
            end else begin
               nxt_st.cnt = st_ff.cnt + CRC_CNT_ONE;
            end
         end
         ovf_set = wrap & ~baud;
         if (trig) begin
            exf_set = 1'b1;
            if (!baud) begin
               nxt_st.cnt = st_ff.rld;
            end
         end
      end

      // control byte; flags clear on written zero, hardware set wins
      if (wr_ctrl) begin
         nxt_st.ctrl = pwdata[7:0];
      end
      ovf_keep = st_ff.ctrl[CRC_BIT_OVF] & (~wr_ctrl | pwdata[CRC_BIT_OVF]);
      exf_keep = st_ff.ctrl[CRC_BIT_EXF] & (~wr_ctrl | pwdata[CRC_BIT_EXF]);
      nxt_st.ctrl[CRC_BIT_OVF] = ovf_keep | ovf_set;
      nxt_st.ctrl[CRC_BIT_EXF] = (exf_keep | exf_set) ^ exf_tog;
      if (wr_mode) begin
         nxt_st.down_count_enable = pwdata[CRC_BIT_DOWN_COUNT_ENABLE];
      end
      if (wr_ie) begin
         nxt_st.ie = pwdata[CRC_BIT_IE];
      end
      // software writes to count and reload win over hardware updates
      if (wr_cnt && pstrb[0]) begin
         nxt_st.cnt[7:0] = pwdata[7:0];
      end
      if (wr_cnt && pstrb[1]) begin
         nxt_st.cnt[15:8] = pwdata[15:8];
      end
      if (wr_rld && pstrb[0]) begin
         nxt_st.rld[7:0] = pwdata[7:0];
      end
      if (wr_rld && pstrb[1]) begin
         nxt_st.rld[15:8] = pwdata[15:8];
      end

      // serial port rate clock selection
      nxt_st.rx_tick = st_ff.ctrl[CRC_BIT_RCLK] ? wrap : other_timer_ovf;
      nxt_st.tx_tick = st_ff.ctrl[CRC_BIT_TX_CLOCK_SELECT] ? wrap : other_timer_ovf;

      // shared interrupt, external flag masked while down-counting
      nxt_st.irq = st_ff.ie & (st_ff.ctrl[CRC_BIT_OVF] |
                   (st_ff.ctrl[CRC_BIT_EXF] & ~st_ff.down_count_enable));

      // read data latched in the setup cycle
      rd = CRC_DATA_ZERO;
      case (offs)
         CRC_ADDR_CTRL: begin
            rd[7:0] = st_ff.ctrl;
         end
         CRC_ADDR_MODE: begin
            rd[CRC_BIT_DOWN_COUNT_ENABLE] = st_ff.down_count_enable;
         end
         CRC_ADDR_COUNT: begin
            rd[15:0] = st_ff.cnt;
         end
         CRC_ADDR_RELOAD: begin
            rd[15:0] = st_ff.rld;
         end
         CRC_ADDR_IE: begin
            rd[CRC_BIT_IE] = st_ff.ie;
         end
         default: begin
            rd = CRC_DATA_ZERO;
         end
      endcase
      if (setup) begin
         nxt_st.rdata = hit ? rd : CRC_DATA_ZERO;
         nxt_st.slverr = ~hit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '{ctrl: CRC_CTRL_RST, down_count_enable: 1'b0, ie: 1'b0,
                    cnt: CRC_CNT_RST, rld: CRC_CNT_RST, rdata: CRC_DATA_ZERO,
                    slverr: 1'b0, irq: 1'b0, rx_tick: 1'b0, tx_tick: 1'b0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign pready = 1'b1; // zero wait states
   assign prdata = st_ff.rdata;
   assign pslverr = st_ff.slverr;
   assign rx_baud_tick = st_ff.rx_tick;
   assign tx_baud_tick = st_ff.tx_tick;
   assign irq = st_ff.irq;
endmodule : crc_counter16

// [test/crc_pin_src.sv]
`timescale 1ns/1ps
module crc_pin_src (
   // clock
   input wire logic pclk,
   // pins, idle high
   output logic cnt_pin,
   output logic trg_pin
);
   initial begin
      cnt_pin = 1'b1;
      trg_pin = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////
   // count pulses, low 3 cycles and high 4 cycles each
   task pulse_cnt(input int n);
      repeat (n) begin
         @(posedge pclk) cnt_pin <= 1'b0;
         repeat (3) @(posedge pclk);
         cnt_pin <= 1'b1;
         repeat (3) @(posedge pclk);
      end
      repeat (4) @(posedge pclk);
   endtask : pulse_cnt
   // one trigger falling edge
   task fall_trg;
      @(posedge pclk) trg_pin <= 1'b0;
      repeat (4) @(posedge pclk);
      trg_pin <= 1'b1;
      repeat (6) @(posedge pclk);
   endtask : fall_trg
   // direction level
   task hold_trg(input logic v);
      @(posedge pclk) trg_pin <= v;
      repeat (6) @(posedge pclk);
   endtask : hold_trg
endmodule : crc_pin_src

// [test/crc_counter16_props.sv]
`timescale 1ns/1ps
module crc_counter16_props
   import crc_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // rate clocks and interrupt
   input wire logic other_timer_ovf,
   input wire logic rx_baud_tick,
   input wire logic tx_baud_tick,
   input wire logic irq
);
   logic wr_en;
   logic [7:0] ctl_ff;
   logic ie_ff;
   assign wr_en = psel && penable && pwrite && pstrb[0];
   // shadow of control and enable writes
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_ff <= 8'h00;
         ie_ff <= 1'b0;
      end else if (wr_en) begin
         if (paddr == {24'h00_0000, CRC_ADDR_CTRL}) ctl_ff <= pwdata[7:0];
         if (paddr == {24'h00_0000, CRC_ADDR_IE}) ie_ff <= pwdata[0];
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_bad;
      s_setup ##0 (paddr[31:8] != 24'h00_0000);
   endsequence
   a_ready_one: assert property (pready) else $error("pready low");
   a_bad_err: assert property (s_bad |=> pslverr) else $error("no error");
   a_bad_zero: assert property (s_bad |=> prdata == 32'h0000_0000) else $error("bad data");
   a_map_ok: assert property (s_setup ##0 paddr == {24'h00_0000, CRC_ADDR_CTRL}
      |=> !pslverr && prdata[31:8] == 24'h00_0000) else $error("ctrl read wrong");
   a_data_hold: assert property (!(psel && !penable) |=> $stable(prdata) && $stable(pslverr))
      else $error("read data moved");
   a_irq_gate: assert property (!ie_ff && !$past(ie_ff) |-> !irq)
      else $error("irq while disabled");
   a_rx_other: assert property (!ctl_ff[5] && !$past(ctl_ff[5])
      |-> rx_baud_tick == $past(other_timer_ovf)) else $error("rx tick source");
   a_tx_other: assert property (!ctl_ff[4] && !$past(ctl_ff[4])
      |-> tx_baud_tick == $past(other_timer_ovf)) else $error("tx tick source");
   a_run_gate: assert property (ctl_ff[5] && $past(ctl_ff[5]) && !$past(ctl_ff[2])
      && !$past(ctl_ff[2], 2) |-> !rx_baud_tick) else $error("tick while stopped");
endmodule : crc_counter16_props
bind crc_counter16 crc_counter16_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .other_timer_ovf, .rx_baud_tick,
   .tx_baud_tick, .irq);

// [test/crc_counter16_tb_top.sv]
`timescale 1ns/1ps
module crc_counter16_tb_top
   import crc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, ovf, pready, pslverr, err, rx, tx, irq;
   logic cpin, tpin;
   logic [31:0] paddr, pwdata, prdata, rd;
   logic [3:0] pstrb;
   int n_mismatch, total_checks, k, nt;
   localparam logic [31:0] A_CT = 32'h0000_0000;
   localparam logic [31:0] A_MD = 32'h0000_0004;
   localparam logic [31:0] A_CN = 32'h0000_0008;
   localparam logic [31:0] A_RL = 32'h0000_000c;
   localparam logic [31:0] A_IE = 32'h0000_0010;
   crc_counter16 dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ext_count_pin(cpin), .ext_trigger_pin(tpin),
      .other_timer_ovf(ovf), .rx_baud_tick(rx), .tx_baud_tick(tx), .irq(irq));
   crc_pin_src src (.pclk(pclk), .cnt_pin(cpin), .trg_pin(tpin));
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   ////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : end_sim
   task ck(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : ck
   // one apb transfer, read data in rd and err
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (pready !== 1'b1) begin
         n_mismatch++;
         end_sim();
      end
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask : cyc
   ////////////////////////////////////////////////////////////////////////
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, ovf} = 4'h0;
      paddr = 32'h0000_0000;
      pwdata = 32'h0000_0000;
      pstrb = 4'hf;
      n_mismatch = 0;
      total_checks = 0;
      cyc(2);
      presetn <= 1'b1;
      // reset state and refusals
      apb(0, A_MD, 0);
      ck(rd, 0);
      apb(0, 32'h0000_0014, 0);
      ck({31'h0, err}, 1);
      apb(0, 32'h0000_0100, 0);
      ck({31'h0, err}, 1);
      // other timer ticks pass through while both selects are clear
      @(posedge pclk) ovf <= 1'b1;
      @(posedge pclk) ovf <= 1'b0;
      @(negedge pclk) ck({30'h0, rx, tx}, 3);
      @(negedge pclk) ck({30'h0, rx, tx}, 0);
      // stopped counter holds, only enabled byte lanes written
      apb(1, A_CN, 32'h0000_1234);
      cyc(30);
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_1234);
      pstrb <= 4'h2;
      apb(1, A_CN, 32'h0000_ab99);
      pstrb <= 4'hf;
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_ab34);
      // internal tick every 12 cycles
      apb(1, A_CN, 0);
      apb(1, A_CT, 32'h0000_0004);
      cyc(116);
      apb(1, A_CT, 0);
      apb(0, A_CN, 0);
      ck({31'h0, rd >= 9 && rd <= 11}, 1);
      // external count, up auto-reload
      apb(1, A_RL, 32'h0000_1230);
      apb(1, A_CN, 32'h0000_ffff);
      apb(1, A_CT, 32'h0000_0006);
      src.pulse_cnt(1);
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_1230);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_0086);
      ck({31'h0, irq}, 0);
      apb(1, A_IE, 1);
      cyc(3);
      ck({31'h0, irq}, 1);
      // flag kept by one, cleared by zero, never set
      apb(1, A_CT, 32'h0000_0086);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_0086);
      apb(1, A_CT, 32'h0000_0006);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_0006);
      apb(1, A_CT, 32'h0000_0086);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_0006);
      // capture mode
      apb(1, A_CN, 32'h0000_00a5);
      apb(1, A_CT, 32'h0000_000f);
      src.fall_trg();
      apb(0, A_RL, 0);
      ck(rd, 32'h0000_00a5);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_004f);
      cyc(3);
      ck({31'h0, irq}, 1);
      src.pulse_cnt(1);
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_00a6);
      apb(1, A_CN, 32'h0000_ffff);
      src.pulse_cnt(1);
      apb(0, A_CN, 0);
      ck(rd, 0);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_00cf);
      // trigger reload, up only
      apb(1, A_RL, 32'h0000_4000);
      apb(1, A_CN, 32'h0000_0010);
      apb(1, A_CT, 32'h0000_000e);
      src.fall_trg();
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_4000);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_004e);
      // up and down counting
      apb(1, A_CT, 32'h0000_0002);
      apb(1, A_MD, 1);
      src.hold_trg(0);
      apb(1, A_RL, 32'h0000_0100);
      apb(1, A_CN, 32'h0000_0100);
      apb(1, A_CT, 32'h0000_0006);
      src.pulse_cnt(1);
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_ffff);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_00c6);
      apb(1, A_CT, 32'h0000_0046);
      cyc(3);
      ck({31'h0, irq}, 0);
      src.hold_trg(1);
      src.pulse_cnt(1);
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_0100);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_0086);
      apb(1, A_MD, 0);
      apb(1, A_IE, 0);
      // baud mode, trigger sets flag only
      apb(1, A_CT, 32'h0000_0002);
      apb(1, A_RL, 32'h0000_9000);
      apb(1, A_CN, 32'h0000_0050);
      apb(1, A_CT, 32'h0000_003f);
      src.fall_trg();
      apb(0, A_CN, 0);
      ck(rd, 32'h0000_0050);
      apb(0, A_RL, 0);
      ck(rd, 32'h0000_9000);
      apb(0, A_CT, 0);
      ck(rd, 32'h0000_007f);
      // baud mode, internal state-time ticks, sampled between edges
      apb(1, A_RL, 32'h0000_ffff);
      apb(1, A_CN, 32'h0000_ffff);
      apb(1, A_CT, 32'h0000_0034);
      nt = 0;
      for (k = 0; k < 40; k++) begin
         @(negedge pclk);
         if (rx === 1'b1 && tx === 1'b1) nt++;
      end
      ck({31'h0, nt >= 19 && nt <= 21}, 1);
      apb(0, A_CT, 0);
      ck({31'h0, rd[7]}, 0);
      apb(1, A_CT, 32'h0000_0030);
      cyc(4);
      end_sim();
   end
endmodule : crc_counter16_tb_top
